// *** shared/ciu_map.svh ***
`ifndef CIU_MAP_SVH
`define CIU_MAP_SVH

// ---------------------------------------------------------------
// apb register offsets (byte addresses)
// ---------------------------------------------------------------
`define CIU_OFS_INSTR 12'h000
`define CIU_OFS_DATA 12'h004
`define CIU_OFS_STATUS 12'h008

// ---------------------------------------------------------------
// memory geometry and fixed codes
// ---------------------------------------------------------------
`define CIU_CHAR_DEPTH 128
`define CIU_GLYPH_DEPTH 64
`define CIU_SPACE_CODE 8'h20
`define CIU_LINE_LAST 7'h27
`define CIU_LINE2_FIRST 7'h40
`define CIU_LINE2_LAST 7'h67
`define CIU_GLYPH_LAST 6'h3f
`define CIU_SHIFT_LAST 6'h27
`define CIU_CURSOR_ROW 3'h7
`define CIU_ALL_PIXELS 5'h1f

// ---------------------------------------------------------------
// status register field positions
// ---------------------------------------------------------------
`define CIU_ST_DISP_ON 0
`define CIU_ST_CURSOR_ON 1
`define CIU_ST_BLINK_ON 2
`define CIU_ST_INC_DIR 3
`define CIU_ST_SHIFT_EN 4
`define CIU_ST_GLYPH_SEL 5
`define CIU_ST_BLINK_PHASE 6
`define CIU_ST_FILLING 7
`define CIU_ST_BUS_WIDTH 8
`define CIU_ST_LINES 9
`define CIU_ST_LUM_LO 10
`define CIU_ST_LUM_HI 11
`define CIU_ST_SHIFT_LSB 16

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define CIU_CLK_KHZ 20000
`define CIU_BLINK_HALF_MS 500
`define CIU_BLINK_HALF_CYCLES (`CIU_BLINK_HALF_MS * `CIU_CLK_KHZ)

`endif

// *** shared/ciu_pkg.sv ***
package ciu_pkg;

    // fill sequencer states, one-hot
    typedef enum logic [1:0] {
        CIU_IDLE = 2'b01,
        CIU_FILL = 2'b10
    } ciu_state_t;

endpackage

// *** verilog/ciu_char_display.sv ***
// Our own choices: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`include "ciu_map.svh"
// Overview of operation
// [R1] glyph memory of 64 bytes holds rows for eight 5x8 user characters
// [R2] unused glyph locations are plain read/write storage
// [R3] codes 00H-07H and 08H-0FH both pick user glyphs; bit 3 ignored
// [R4] glyph address = code[2:0] then row; data bits 4..0 are pixels
// [R5] instruction decoded by its most significant set bit
// [R6] clear display fills character memory with 20H, glyphs untouched
// [R7] clear also zeroes counter, cancels shift, sets increment direction
// [R8] cursor home zeroes counter and cancels shift, memories untouched
// [R9] entry mode stores direction and shift; direction 0 decrements, shifts right
// [R10] direction 1 increments counter, shifts display left on character writes
// [R11] shift only on character memory writes when enabled
// [R12] entry mode and display control touch only their own bits
// [R13] display-on bit blanks or shows the screen
// [R14] cursor-on lights the eighth pixel row at the cursor
// [R15] blink alternates full block with cursor character, about 1Hz 50%
// [R16] register select low means instruction, high means data
// [R17] instruction read returns counter on bits 6..0, busy bit 0
// [R18] data access goes to memory of last address-set, at counter
// [R19] glyph accesses wrap counter between 3FH and 00H
// [R20] blink phase toggles from a clock divider about every half second
// [R21] don't-care instruction bits are ignored
module ciu_char_display #(
    parameter int BLINK_HALF_CYCLES = `CIU_BLINK_HALF_CYCLES
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // display scan port
    input wire logic [6:0] scan_pos,
    input wire logic [2:0] scan_row,
    output logic [7:0] scan_code,
    output logic scan_user,
    output logic [4:0] scan_pixels,
    // display state
    output logic display_on,
    output logic [5:0] shift_offset,
    output logic [1:0] luminance
);

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    logic [7:0] char_mem [`CIU_CHAR_DEPTH];
    logic [7:0] glyph_mem [`CIU_GLYPH_DEPTH];
    ciu_pkg::ciu_state_t state;
    logic was_idle;
    logic [6:0] fill_addr;
    logic [6:0] address_counter;
    logic glyph_sel;
    logic inc_dir;
    logic shift_en;
    logic cursor_on;
    logic blink_on;
    logic bus_width_select;
    logic two_lines;
    logic luminance_select_hi;
    logic luminance_select_lo;
    logic [31:0] blink_cnt;
    logic blink_phase;

    // ---------------------------------------------------------------
    // apb decode
    // ---------------------------------------------------------------
    // pready waits one idle cycle so prdata was sampled from settled memories
    wire idle = (state == ciu_pkg::CIU_IDLE);
    wire hit_instr = (paddr == `CIU_OFS_INSTR);
    wire hit_data = (paddr == `CIU_OFS_DATA);
    wire hit_status = (paddr == `CIU_OFS_STATUS);
    wire mapped = hit_instr | hit_data | hit_status;
    wire done = psel & penable & pready;
    wire instr_wr = done & pwrite & hit_instr; // R16
    wire data_wr = done & pwrite & hit_data; // R16
    wire data_rd = done & ~pwrite & hit_data;
    wire [7:0] wbyte = pwdata[7:0];

    assign pready = idle & was_idle;
    assign pslverr = done & (~mapped | (pwrite & hit_status));

    // ---------------------------------------------------------------
    // instruction decode by leading one
    // ---------------------------------------------------------------
    wire op_ddr_set = wbyte[7]; // R5
    wire op_cg_set = (wbyte[7:6] == 2'b01); // R5
    wire op_func = (wbyte[7:5] == 3'b001); // R5
    wire op_shift = (wbyte[7:4] == 4'b0001); // R5
    wire op_dctl = (wbyte[7:3] == 5'b00001); // R5
    wire op_entry = (wbyte[7:2] == 6'b000001); // R5
    wire op_home = (wbyte[7:1] == 7'b0000001); // R5 R21
    wire op_clear = (wbyte == 8'h01); // R5
    wire [5:0] glyph_addr = address_counter[5:0];

    // ---------------------------------------------------------------
    // counter stepping
    // ---------------------------------------------------------------
    // character memory skips the gaps between the two lines
    function automatic logic [6:0] ciu_step(input logic [6:0] ac, input logic up, input logic glyph);
        logic [6:0] r;
        r = up ? ac + 7'h01 : ac - 7'h01;
        if (glyph) begin
            r = {1'b0, r[5:0]}; // R19
        end else if (up && ac == `CIU_LINE_LAST) begin
            r = `CIU_LINE2_FIRST;
        end else if (up && ac == `CIU_LINE2_LAST) begin
            r = 7'h00;
        end else if (!up && ac == `CIU_LINE2_FIRST) begin
            r = `CIU_LINE_LAST;
        end else if (!up && ac == 7'h00) begin
            r = `CIU_LINE2_LAST;
        end
        return r;
    endfunction

    function automatic logic [5:0] ciu_rot(input logic [5:0] s, input logic left);
        logic [5:0] r;
        r = 6'h00;
        if (left) begin
            r = (s == `CIU_SHIFT_LAST) ? 6'h00 : s + 6'h01;
        end else begin
            r = (s == 6'h00) ? `CIU_SHIFT_LAST : s - 6'h01;
        end
        return r;
    endfunction

    wire [6:0] ac_stepped = ciu_step(address_counter, inc_dir, glyph_sel); // R9 R10
    wire [6:0] ac_shift_cmd = ciu_step(address_counter, wbyte[2], 1'b0);
    wire auto_shift = data_wr & ~glyph_sel & shift_en; // R11

    // ---------------------------------------------------------------
    // read data
    // ---------------------------------------------------------------
    wire [7:0] mem_rd = glyph_sel ? glyph_mem[glyph_addr] : char_mem[address_counter]; // R18
    wire [31:0] status_word = {10'h000, shift_offset, 4'h0,
        luminance_select_hi, luminance_select_lo, two_lines, bus_width_select,
        ~idle, blink_phase, glyph_sel, shift_en, inc_dir, blink_on, cursor_on, display_on};
    wire [31:0] rd_value = hit_instr ? {24'h000000, 1'b0, address_counter} : // R17
        hit_data ? {24'h000000, mem_rd} : hit_status ? status_word : 32'h00000000;

    // sampled every selected cycle; the master reads the copy from the previous edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (psel) begin
            prdata <= rd_value;
        end
    end

    // ---------------------------------------------------------------
    // fill sequencer
    // ---------------------------------------------------------------
    // starts in fill so character memory holds spaces after reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ciu_pkg::CIU_FILL;
            fill_addr <= 7'h00;
            was_idle <= 1'b0;
        end else begin
            was_idle <= idle;
            unique case (state)
                ciu_pkg::CIU_IDLE: begin
                    if (instr_wr && op_clear) begin
                        state <= ciu_pkg::CIU_FILL; // R6
                        fill_addr <= 7'h00;
                    end
                end
                ciu_pkg::CIU_FILL: begin
                    fill_addr <= fill_addr + 7'h01;
                    if (fill_addr == 7'h7f) begin
                        state <= ciu_pkg::CIU_IDLE;
                    end
                end
            endcase
        end
    end

    // ---------------------------------------------------------------
    // memories
    // ---------------------------------------------------------------
    // no reset on the arrays; the fill covers character memory
    always_ff @(posedge pclk) begin
        if (!idle) begin
            char_mem[fill_addr] <= `CIU_SPACE_CODE; // R6
        end else if (data_wr && !glyph_sel) begin
            char_mem[address_counter] <= wbyte; // R18
        end
    end

    // glyph memory keeps all 8 bits so spare locations are general storage
    always_ff @(posedge pclk) begin
        if (data_wr && glyph_sel) begin
            glyph_mem[glyph_addr] <= wbyte; // R1 R2
        end
    end

    // ---------------------------------------------------------------
    // address counter and shift
    // ---------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            address_counter <= 7'h00;
            glyph_sel <= 1'b0;
            shift_offset <= 6'h00;
        end else if (instr_wr) begin
            if (op_ddr_set) begin
                address_counter <= wbyte[6:0];
                glyph_sel <= 1'b0;
            end else if (op_cg_set) begin
                address_counter <= {1'b0, wbyte[5:0]};
                glyph_sel <= 1'b1;
            end else if (op_shift) begin
                // cursor/display shift: always lands in character memory
                address_counter <= ac_shift_cmd;
                glyph_sel <= 1'b0;
                if (wbyte[3]) begin
                    shift_offset <= ciu_rot(shift_offset, ~wbyte[2]);
                end
            end else if (op_home || op_clear) begin
                address_counter <= 7'h00; // R7 R8
                glyph_sel <= 1'b0;
                shift_offset <= 6'h00; // R7 R8
            end
        end else if (data_wr || data_rd) begin
            address_counter <= ac_stepped; // R9 R10 R19
            if (auto_shift) begin
                shift_offset <= ciu_rot(shift_offset, inc_dir); // R9 R10 R11
            end
        end
    end

    // ---------------------------------------------------------------
    // mode bits
    // ---------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            inc_dir <= 1'b1;
            shift_en <= 1'b0;
            display_on <= 1'b0;
            cursor_on <= 1'b0;
            blink_on <= 1'b0;
            bus_width_select <= 1'b1;
            two_lines <= 1'b1;
            luminance_select_hi <= 1'b0;
            luminance_select_lo <= 1'b0;
        end else if (instr_wr) begin
            if (op_clear) begin
                inc_dir <= 1'b1; // R7
            end
            if (op_entry) begin
                inc_dir <= wbyte[1]; // R9 R12
                shift_en <= wbyte[0]; // R9 R12
            end
            if (op_dctl) begin
                display_on <= wbyte[2]; // R13 R12
                cursor_on <= wbyte[1]; // R14
                blink_on <= wbyte[0]; // R15
            end
            if (op_func) begin
                bus_width_select <= wbyte[4]; // R21
                two_lines <= wbyte[3];
                luminance_select_hi <= wbyte[1];
                luminance_select_lo <= wbyte[0];
            end
        end
    end

    assign luminance = {luminance_select_hi, luminance_select_lo};

    // ---------------------------------------------------------------
    // blink divider
    // ---------------------------------------------------------------
    // free running, so the phase is arbitrary whenever blink is turned on
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            blink_cnt <= 32'h00000000;
            blink_phase <= 1'b0;
        end else if (blink_cnt == 32'(BLINK_HALF_CYCLES - 1)) begin
            blink_cnt <= 32'h00000000;
            blink_phase <= ~blink_phase; // R20 R15
        end else begin
            blink_cnt <= blink_cnt + 32'h00000001;
        end
    end

    // ---------------------------------------------------------------
    // scan output
    // ---------------------------------------------------------------
    // user glyph rows are looked up here; rom characters are drawn downstream
    wire [7:0] sc_code = char_mem[scan_pos];
    wire sc_user = (sc_code[7:4] == 4'h0); // R3
    wire [4:0] sc_glyph = glyph_mem[{sc_code[2:0], scan_row}][4:0]; // R3 R4
    wire at_cursor = (scan_pos == address_counter) & ~glyph_sel;
    wire blink_fill = at_cursor & blink_on & blink_phase; // R15
    wire cursor_row = at_cursor & cursor_on & (scan_row == `CIU_CURSOR_ROW); // R14
    wire [4:0] sc_pix = (blink_fill | cursor_row) ? `CIU_ALL_PIXELS : (sc_user ? sc_glyph : 5'h00);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scan_code <= 8'h00;
            scan_user <= 1'b0;
            scan_pixels <= 5'h00;
        end else begin
            scan_code <= sc_code;
            scan_user <= sc_user | blink_fill | cursor_row;
            scan_pixels <= display_on ? sc_pix : 5'h00; // R13
        end
    end

endmodule // ciu_char_display

// *** bench/ciu_char_display_checker.sv ***
`timescale 1ns/1ps
module ciu_char_display_checker (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // scan and display state
    input wire logic [7:0] scan_code,
    input wire logic scan_user,
    input wire logic [4:0] scan_pixels,
    input wire logic display_on,
    input wire logic [5:0] shift_offset,
    input wire logic [1:0] luminance
);
    // completed transfers; instruction writes decoded from the low byte
    wire logic xfer = psel & penable & pready;
    wire logic wr_instr = xfer & pwrite & (paddr == 12'h000);
    wire logic rd_instr = xfer & !pwrite & (paddr == 12'h000);
    wire logic rd_data = xfer & !pwrite & (paddr == 12'h004);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_clear_fill; wr_instr && pwdata[7:0] == 8'h01 |=> !pready [*8]; endproperty
    a_clear_fill: assert property (p_clear_fill) else $error("clear did not hold off the bus");
    property p_clear_shift; wr_instr && pwdata[7:0] == 8'h01 |-> ##[1:3] shift_offset == 6'h00; endproperty
    a_clear_shift: assert property (p_clear_shift) else $error("clear left a shift");
    property p_home_shift; wr_instr && pwdata[7:1] == 7'h01 |-> ##[1:3] shift_offset == 6'h00; endproperty
    a_home_shift: assert property (p_home_shift) else $error("home left a shift");
    property p_busy_zero; rd_instr |-> prdata[31:7] == 25'h0; endproperty
    a_busy_zero: assert property (p_busy_zero) else $error("busy bit not zero");
    property p_read_noshift; rd_data |=> $stable(shift_offset); endproperty
    a_read_noshift: assert property (p_read_noshift) else $error("data read shifted");
    property p_disp_ctl; wr_instr && pwdata[7:3] == 5'h01 |=> display_on == $past(pwdata[2]); endproperty
    a_disp_ctl: assert property (p_disp_ctl) else $error("display on not taken");
    property p_func_set; wr_instr && pwdata[7:5] == 3'h1 |=> luminance == $past(pwdata[1:0]); endproperty
    a_func_set: assert property (p_func_set) else $error("luminance not taken");
    property p_entry_only; wr_instr && pwdata[7:2] == 6'h01 |=> $stable(display_on) && $stable(luminance); endproperty
    a_entry_only: assert property (p_entry_only) else $error("entry mode touched other state");
    property p_blank; !display_on && !$past(display_on) |-> scan_pixels == 5'h00; endproperty
    a_blank: assert property (p_blank) else $error("pixels lit while blank");
    // the scan flops leave reset holding code 00 unflagged; judge only what a scan produced
    property p_user_code; $past(presetn) && scan_code[7:4] == 4'h0 |-> scan_user; endproperty
    a_user_code: assert property (p_user_code) else $error("user code not flagged");
    // main scenarios seen at least once
    cover property (wr_instr && pwdata[7:0] == 8'h01);
    cover property (xfer && pslverr);
    cover property (scan_pixels == 5'h1f);
endmodule // ciu_char_display_checker

bind ciu_char_display ciu_char_display_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .scan_code(scan_code), .scan_user(scan_user), .scan_pixels(scan_pixels),
    .display_on(display_on), .shift_offset(shift_offset), .luminance(luminance));

// *** bench/ciu_host_model.sv ***
`timescale 1ns/1ps
module ciu_host_model (
    // clock
    input wire logic pclk,
    // apb master
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
    end
    // one transfer; pready is sampled at each rising edge of the access phase and the request
    // stands until the edge that completes it; a hang is left to the bench's watchdog
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        // values seen here are those sampled at the completion edge
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule // ciu_host_model

// *** bench/tb.sv ***
`timescale 1ns/1ps
module tb;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, scan_user, display_on;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [6:0] scan_pos;
    logic [2:0] scan_row;
    logic [7:0] scan_code;
    logic [4:0] scan_pixels, p;
    logic [5:0] shift_offset;
    logic [1:0] luminance;
    logic e;
    int failures = 0;
    int n_tests = 0;
    int n;
    // short blink half period keeps the blink test to a few dozen cycles
    ciu_char_display #(.BLINK_HALF_CYCLES(8)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .scan_pos(scan_pos), .scan_row(scan_row),
        .scan_code(scan_code), .scan_user(scan_user), .scan_pixels(scan_pixels),
        .display_on(display_on), .shift_offset(shift_offset), .luminance(luminance));
    ciu_host_model host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic w(input logic [11:0] a, input logic [7:0] d);
        host.xfer(1'b1, a, {24'h0, d}, q, e);
    endtask
    task automatic r(input logic [11:0] a);
        host.xfer(1'b0, a, 32'h0, q, e);
    endtask
    // scan output is registered; let it settle before looking
    task automatic scan(input logic [6:0] pos, input logic [2:0] row);
        @(posedge pclk);
        scan_pos <= pos;
        scan_row <= row;
        repeat (3) @(posedge pclk);
        @(negedge pclk);
        p = scan_pixels;
    endtask
    task automatic lit_count();
        scan(7'h00, 3'h0);
        n = 0;
        repeat (32) begin
            @(negedge pclk);
            if (scan_pixels === 5'h1f) n++;
        end
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    task automatic t_reset();
        r(12'h008);
        chk("status", 32'h0000_0308, q & ~32'h40);
        r(12'h000);
        chk("counter", 32'h0, q);
        r(12'h004);
        chk("char 00", 32'h20, q);
        w(12'h000, 8'h3e);
        r(12'h008);
        chk("luminance", 32'h2, {30'h0, q[11:10]});
        host.xfer(1'b0, 12'h00c, 32'h0, q, e);
        chk("unmapped err", 32'h1, {31'h0, e});
        host.xfer(1'b1, 12'h008, 32'h0, q, e);
        chk("status write err", 32'h1, {31'h0, e});
        $display("test reset done");
    endtask
    task automatic t_glyph();
        w(12'h000, 8'h7e);
        w(12'h004, 8'haa);
        w(12'h004, 8'h55);
        w(12'h004, 8'h11);
        r(12'h000);
        chk("glyph wrap", 32'h01, q);
        w(12'h000, 8'h7e);
        r(12'h004);
        chk("glyph 3e", 32'haa, q);
        r(12'h004);
        chk("glyph 3f", 32'h55, q);
        w(12'h000, 8'h4a);
        w(12'h004, 8'hf5);
        w(12'h000, 8'h85);
        w(12'h004, 8'h09);
        w(12'h000, 8'h0c);
        w(12'h000, 8'h40);
        scan(7'h05, 3'h2);
        chk("alias pixels", 32'h15, {27'h0, p});
        w(12'h000, 8'h08);
        scan(7'h05, 3'h2);
        chk("blank pixels", 32'h0, {27'h0, p});
        $display("test glyph done");
    endtask
    task automatic t_entry();
        w(12'h000, 8'h07);
        w(12'h000, 8'ha7);
        w(12'h004, 8'h41);
        r(12'h000);
        chk("counter 27 up", 32'h40, q);
        r(12'h004);
        r(12'h008);
        chk("left shift", 32'h1, {26'h0, q[21:16]});
        w(12'h000, 8'h05);
        w(12'h004, 8'h42);
        r(12'h000);
        chk("counter down", 32'h40, q);
        r(12'h008);
        chk("right shift", 32'h0, {26'h0, q[21:16]});
        // shift command with display move and direction 0: counter down, view left
        w(12'h000, 8'h18);
        r(12'h000);
        chk("shift cmd counter", 32'h27, q);
        r(12'h008);
        chk("shift cmd offset", 32'h1, {26'h0, q[21:16]});
        $display("test entry done");
    endtask
    task automatic t_clear();
        w(12'h000, 8'h07);
        w(12'h000, 8'h90);
        w(12'h004, 8'h42);
        w(12'h000, 8'h03);
        r(12'h008);
        chk("home shift", 32'h0, {26'h0, q[21:16]});
        w(12'h000, 8'h90);
        r(12'h004);
        chk("home keeps char", 32'h42, q);
        w(12'h000, 8'h04);
        w(12'h000, 8'h01);
        r(12'h008);
        chk("clear inc dir", 32'h1, {31'h0, q[3]});
        r(12'h000);
        chk("clear counter", 32'h0, q);
        w(12'h000, 8'h90);
        r(12'h004);
        chk("cleared char", 32'h20, q);
        w(12'h000, 8'h7e);
        r(12'h004);
        chk("glyph kept", 32'haa, q);
        $display("test clear done");
    endtask
    task automatic t_blink();
        w(12'h000, 8'h80);
        w(12'h000, 8'h0e);
        scan(7'h00, 3'h7);
        chk("cursor row", 32'h1f, {27'h0, p});
        w(12'h000, 8'h0d);
        lit_count();
        chk("blink duty", 32'h1, {31'h0, n >= 14 && n <= 18});
        w(12'h000, 8'h0c);
        lit_count();
        chk("no blink", 32'h0, n);
        $display("test blink done");
    endtask
    // watchdog reckoned at over thirty times the expected run of some 530 cycles
    initial begin
        repeat (20000) @(posedge pclk);
        failures++;
        results();
    end
    initial begin
        presetn = 1'b0;
        scan_pos = 7'h00;
        scan_row = 3'h0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_glyph();
        t_entry();
        t_clear();
        t_blink();
        results();
    end
endmodule // tb
